// [src/ccvs_pkg.sv]
package ccvs_pkg;
    // Register map and field layout
    localparam logic [15:0] OSC_CTRL_OFFSET = 16'hff00;
    localparam int CLK_SEL_BIT = 3;
    localparam int FAST_EN_BIT = 2;
    localparam int UNUSED_BIT = 1;
    localparam int VOLT_SEL_BIT = 0;
    localparam logic [3:0] OSC_CTRL_RESET = 4'h0;
    localparam logic [3:0] OSC_CTRL_WMASK = 4'hd;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int ACLK_PERIOD_NS = 25;
    localparam int INSTR_SRC_CLOCKS = 2;
    localparam int SLOW_INSTR_NS = 61000;
    localparam int FAST_INSTR_NS = 500;

    typedef enum logic {
        CCVS_SLOW_OSC,
        CCVS_FAST_OSC
    } ccvs_src_t;
endpackage

// [src/ccvs_clk_if.sv]
`timescale 1ns/1ps
interface ccvs_clk_if;
    logic cpu_clk;
    logic cpu_clk_rise;
    modport src (output cpu_clk, output cpu_clk_rise);
    modport snk (input cpu_clk, input cpu_clk_rise);
endinterface

// [src/ccvs_clk_mux.sv]
`timescale 1ns/1ps
module ccvs_clk_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow_oscillator,
    input wire logic fast_oscillator,
    input wire logic sel_fast,
    output logic active_fast,
    ccvs_clk_if.src clk
);
    typedef enum logic {
        CCVS_RUN,
        CCVS_HOLD
    } ccvs_mux_state_t;

    logic [1:0] slow_sync_q;
    logic [1:0] fast_sync_q;
    ccvs_mux_state_t state_q;
    ccvs_pkg::ccvs_src_t cur_q;
    logic clk_q;
    logic rise_q;
    logic cur_level;
    logic req_level;
    logic want_switch;
    logic clk_d;

    assign cur_level = (cur_q == ccvs_pkg::CCVS_FAST_OSC) ? fast_sync_q[1] : slow_sync_q[1];
    assign req_level = sel_fast ? fast_sync_q[1] : slow_sync_q[1];
    assign want_switch = sel_fast != (cur_q == ccvs_pkg::CCVS_FAST_OSC);
    // Output finishes its current high phase, then parks low while a switch is pending, so no runt pulse escapes
    assign clk_d = (state_q == CCVS_RUN) && !(want_switch && !cur_level) && cur_level; // RULE17

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_sync_q <= 2'h0;
            fast_sync_q <= 2'h0;
        end else begin
            slow_sync_q <= {slow_sync_q[0], slow_oscillator};
            fast_sync_q <= {fast_sync_q[0], fast_oscillator};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= CCVS_RUN;
            cur_q <= ccvs_pkg::CCVS_SLOW_OSC;
            clk_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            clk_q <= clk_d;
            rise_q <= clk_d && !clk_q;
            case (state_q)
                CCVS_RUN: begin
                    if (want_switch && !cur_level) begin
                        state_q <= CCVS_HOLD; // RULE17
                    end
                end
                CCVS_HOLD: begin
                    if (!want_switch) begin
                        state_q <= CCVS_RUN;
                    end else if (!req_level) begin
                        cur_q <= sel_fast ? ccvs_pkg::CCVS_FAST_OSC : ccvs_pkg::CCVS_SLOW_OSC; // RULE17
                        state_q <= CCVS_RUN;
                    end
                end
                default: state_q <= CCVS_RUN;
            endcase
        end
    end

    assign clk.cpu_clk = clk_q;
    assign clk.cpu_clk_rise = rise_q;
    assign active_fast = cur_q == ccvs_pkg::CCVS_FAST_OSC;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    hold_low_clk_a: assert property (state_q == CCVS_HOLD |=> !clk_q) // RULE17
        else $error("CPU clock not parked low during switch");
    safe_change_a: assert property ($changed(cur_q) |-> !clk_q && !$past(clk_q)) // RULE17
        else $error("Clock source changed while output high");
endmodule

// [src/ccvs_instr_timer.sv]
`timescale 1ns/1ps
module ccvs_instr_timer #(
    parameter int CLOCKS_PER_INSTR = ccvs_pkg::INSTR_SRC_CLOCKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    ccvs_clk_if.snk clk,
    output logic instr_tick
);
    localparam int CW = $clog2(CLOCKS_PER_INSTR + 1);
    localparam logic [CW-1:0] LAST = CW'(CLOCKS_PER_INSTR - 1);

    logic [CW-1:0] cnt_q;
    logic tick_q;
    logic wrap;

    // One-cycle instruction spans a fixed number of source clocks
    assign wrap = clk.cpu_clk_rise && (cnt_q == LAST); // RULE1

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            if (wrap) begin
                cnt_q <= '0;
            end else if (clk.cpu_clk_rise) begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end

    assign instr_tick = tick_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tick_spacing_a: assert property (tick_q |=> !tick_q) // RULE1
        else $error("Instruction tick repeated back to back");
    count_bound_a: assert property (cnt_q <= LAST) // RULE1
        else $error("Instruction clock count out of range");
endmodule

// [src/ccvs_top.sv]
`timescale 1ns/1ps
// What the document asks of this block and of its software
// RULE1: Instruction takes two source clocks: 61 us slow, 0.5 us fast.
// RULE2: Control register at OSCILLATOR_CONTROL: D3 clock select, D2 fast enable, D0 voltage.
// RULE3: Bit D1 always reads zero; writes to it are dropped.
// RULE4: Reset clears all control bits: slow clock, fast oscillator off, low core.
// RULE5: Voltage select one gives 2.25 V core, zero gives 1.35 V; reads back.
// RULE6: With RC slow oscillator option, core level stays at 2.25 V.
// RULE7: Fast enable one starts fast oscillator, zero stops it; reads back.
// RULE8: Clock select one picks fast oscillator, zero slow; reads back.
// RULE9: Clock select write of one ignored while voltage low and fast oscillator off.
// RULE10: Software raises voltage, waits 2.5 ms, then enables fast oscillator.
// RULE11: Software waits 5 ms after enabling fast oscillator before selecting it.
// RULE12: Software adds generous margin to the fast oscillator settling wait.
// RULE13: Software returns: select slow, stop fast oscillator, then lower voltage.
// RULE14: Stopping fast oscillator and switching back use separate writes.
// RULE15: Software keeps the fast oscillator stopped when speed is not needed.
// RULE16: With RC slow oscillator, software need not touch the voltage.
// RULE17: Clock source change produces no shortened or runt clock pulses.
module ccvs_top #(
    parameter int ADDR_W = 16,
    parameter int CLOCKS_PER_INSTR = ccvs_pkg::INSTR_SRC_CLOCKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slow_oscillator,
    input wire logic fast_oscillator,
    input wire logic rc_slow_osc_option,
    output logic fast_osc_enable,
    output logic core_supply_level,
    output logic cpu_clk,
    output logic cpu_clock_active_fast,
    output logic instr_tick
);
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(ccvs_pkg::OSC_CTRL_OFFSET);

    // Write channel holding registers
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [3:0] w_data_q;
    logic w_strb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Control fields
    logic clk_sel_q;
    logic fast_en_q;
    logic volt_sel_q;
    // Mask option strap synchroniser
    logic [1:0] rc_sync_q;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic ctrl_wr;
    logic core_low;
    logic sel_blocked;
    logic [3:0] ctrl_rd;
    logic clk_sel_d;
    logic fast_en_d;
    logic volt_sel_d;

    ccvs_clk_if u_clk_if ();

    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_hit = aw_addr_q[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]; // RULE2
    assign rd_hit = s_axi_araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]; // RULE2
    assign ctrl_wr = wr_fire && wr_hit && w_strb0_q;

    // Core stays high with the RC option whatever the select holds
    assign core_low = !rc_sync_q[1] && !volt_sel_q; // RULE6
    assign sel_blocked = core_low && !fast_en_q; // RULE9
    assign volt_sel_d = ctrl_wr ? w_data_q[ccvs_pkg::VOLT_SEL_BIT] : volt_sel_q; // RULE5
    assign fast_en_d = ctrl_wr ? w_data_q[ccvs_pkg::FAST_EN_BIT] : fast_en_q; // RULE7
    assign clk_sel_d = (ctrl_wr && !(sel_blocked && w_data_q[ccvs_pkg::CLK_SEL_BIT]))
        ? w_data_q[ccvs_pkg::CLK_SEL_BIT] : clk_sel_q; // RULE8 RULE9

    // Unused bit D1 is tied low on read
    always_comb begin
        ctrl_rd = ccvs_pkg::OSC_CTRL_RESET;
        ctrl_rd[ccvs_pkg::CLK_SEL_BIT] = clk_sel_q; // RULE8
        ctrl_rd[ccvs_pkg::FAST_EN_BIT] = fast_en_q; // RULE7
        ctrl_rd[ccvs_pkg::UNUSED_BIT] = 1'b0; // RULE3
        ctrl_rd[ccvs_pkg::VOLT_SEL_BIT] = volt_sel_q; // RULE5
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync_q <= 2'h0;
        end else begin
            rc_sync_q <= {rc_sync_q[0], rc_slow_osc_option};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel_q <= 1'b0; // RULE4
            fast_en_q <= 1'b0; // RULE4
            volt_sel_q <= 1'b0; // RULE4
        end else begin
            clk_sel_q <= clk_sel_d;
            fast_en_q <= fast_en_d;
            volt_sel_q <= volt_sel_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_fire) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= 4'h0;
            w_strb0_q <= 1'b0;
        end else if (w_fire) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[3:0] & ccvs_pkg::OSC_CTRL_WMASK; // RULE3
            w_strb0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= ccvs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? ccvs_pkg::RESP_OKAY : ccvs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ccvs_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? {28'h000_0000, ctrl_rd} : 32'h0000_0000;
            rresp_q <= rd_hit ? ccvs_pkg::RESP_OKAY : ccvs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign fast_osc_enable = fast_en_q; // RULE7
    assign core_supply_level = !core_low; // RULE5 RULE6
    assign cpu_clk = u_clk_if.cpu_clk;

    ccvs_clk_mux u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .slow_oscillator(slow_oscillator),
        .fast_oscillator(fast_oscillator),
        .sel_fast(clk_sel_q), // RULE8
        .active_fast(cpu_clock_active_fast),
        .clk(u_clk_if.src)
    );

    ccvs_instr_timer #(
        .CLOCKS_PER_INSTR(CLOCKS_PER_INSTR)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk(u_clk_if.snk),
        .instr_tick(instr_tick)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_commit_s;
        wr_fire && wr_hit && w_strb0_q;
    endsequence

    sequence wr_answer_s;
        bvalid_q && bresp_q == ccvs_pkg::RESP_OKAY;
    endsequence

    sequence volt_commit_s;
        wr_fire && wr_hit && w_strb0_q && !rc_sync_q[1];
    endsequence

    sequence sel_commit_s;
        wr_fire && wr_hit && w_strb0_q && !sel_blocked;
    endsequence

    sequence sel_refused_s;
        wr_fire && wr_hit && w_strb0_q && sel_blocked && w_data_q[ccvs_pkg::CLK_SEL_BIT];
    endsequence

    sequence wr_skip_s;
        wr_fire && (!wr_hit || !w_strb0_q);
    endsequence

    sequence wr_miss_s;
        wr_fire && !wr_hit;
    endsequence

    sequence rd_accept_s;
        ar_fire && rd_hit;
    endsequence

    // Reset itself is the antecedent, so the default disable must not apply here
    reset_clears_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> // RULE4
        !clk_sel_q && !fast_en_q && !volt_sel_q)
        else $error("Control bits not cleared by reset");
    unused_zero_a: assert property (rvalid_q |-> rdata_q[ccvs_pkg::UNUSED_BIT] == 1'b0) // RULE3
        else $error("Unused bit read as one");
    map_decode_a: assert property (ar_fire && !rd_hit |=> rvalid_q && rresp_q == ccvs_pkg::RESP_SLVERR) // RULE2
        else $error("Unmapped read not refused");
    volt_write_a: assert property (volt_commit_s |=> // RULE5
        core_supply_level == $past(w_data_q[ccvs_pkg::VOLT_SEL_BIT]))
        else $error("Core level does not follow voltage select");
    rc_fixed_level_a: assert property (rc_sync_q[1] |-> core_supply_level) // RULE6
        else $error("Core level dropped with RC option");
    fast_enable_a: assert property (wr_commit_s |=> fast_osc_enable == $past(w_data_q[ccvs_pkg::FAST_EN_BIT])) // RULE7
        else $error("Fast oscillator enable did not follow write");
    clk_sel_write_a: assert property (sel_commit_s |=> // RULE8
        clk_sel_q == $past(w_data_q[ccvs_pkg::CLK_SEL_BIT]))
        else $error("Clock select did not follow write");
    sel_gate_a: assert property (sel_refused_s |=> // RULE9
        clk_sel_q == $past(clk_sel_q))
        else $error("Blocked clock select write took effect");
    sel_power_a: assert property ($rose(clk_sel_q) |-> !$past(sel_blocked)) // RULE9
        else $error("Clock select rose while gated");
    write_resp_a: assert property (wr_commit_s |=> wr_answer_s) // RULE2
        else $error("Write response missing one cycle after commit");
    resp_hold_a: assert property (bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q)) // RULE2
        else $error("Write response dropped before accepted");
    unmapped_write_a: assert property (wr_miss_s |=> bvalid_q && bresp_q == ccvs_pkg::RESP_SLVERR) // RULE2
        else $error("Unmapped write not refused");
    strobe_gate_a: assert property (wr_skip_s |=> // RULE2
        $stable(clk_sel_q) && $stable(fast_en_q) && $stable(volt_sel_q))
        else $error("Control bits changed by a skipped write");
    no_write_hold_a: assert property (!ctrl_wr |=> // RULE5 RULE7 RULE8
        $stable(clk_sel_q) && $stable(fast_en_q) && $stable(volt_sel_q))
        else $error("Control bits changed without a write");
    read_resp_a: assert property (rd_accept_s |=> rvalid_q && rresp_q == ccvs_pkg::RESP_OKAY) // RULE2
        else $error("Mapped read not answered with OKAY");
    read_back_a: assert property (rd_accept_s |=> // RULE5 RULE7 RULE8
        rdata_q[ccvs_pkg::CLK_SEL_BIT] == $past(clk_sel_q) && rdata_q[ccvs_pkg::FAST_EN_BIT] == $past(fast_en_q)
        && rdata_q[ccvs_pkg::VOLT_SEL_BIT] == $past(volt_sel_q))
        else $error("Read data does not match stored control bits");
    rd_upper_zero_a: assert property (rvalid_q |-> rdata_q[31:4] == 28'h000_0000) // RULE2
        else $error("Read data above the control bits not zero");
    core_low_level_a: assert property (!rc_sync_q[1] && !volt_sel_q |-> !core_supply_level) // RULE5
        else $error("Core level high with voltage select clear");
    core_high_level_a: assert property (volt_sel_q |-> core_supply_level) // RULE5
        else $error("Core level low with voltage select set");
    busy_refuse_a: assert property (bvalid_q |-> !s_axi_awready && !s_axi_wready) // RULE2
        else $error("Write channel accepted while response pending");
    read_busy_a: assert property (rvalid_q |-> !s_axi_arready) // RULE2
        else $error("Read address accepted while data pending");
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] ADDR = ccvs_pkg::OSC_CTRL_OFFSET;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic rc_opt = 1'b0;
    logic [7:0] osc_cnt = '0;
    logic awready, wready, bvalid, arready, rvalid, prev_clk;
    logic fast_en, core_lvl, cpu_clk, act_fast, tick;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    int failures = 0;
    int tests_run = 0;
    int rises = 0;
    int ticks = 0;
    int hi_len = 0;
    // Row: write value, readback, fast enable, core level
    // Leaving the running fast clock and stopping it take two rows
    logic [15:0] rows [10] = '{16'hf511, 16'h8800, 16'h0000, 16'h8000, 16'h4410, 16'hcc10,
                               16'h4410, 16'h1101, 16'h9901, 16'h2000};

    always #12.5 aclk = ~aclk;
    // Bench oscillators: the fast one only runs while enabled
    always @(posedge aclk) osc_cnt <= osc_cnt + 8'h01;

    ccvs_top ccvs_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .slow_oscillator(osc_cnt[3]), .fast_oscillator(osc_cnt[1] & fast_en),
        .rc_slow_osc_option(rc_opt), .fast_osc_enable(fast_en), .core_supply_level(core_lvl),
        .cpu_clk(cpu_clk), .cpu_clock_active_fast(act_fast), .instr_tick(tick));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Count clock rises and ticks; every high phase must last at least two cycles
    always @(posedge aclk) begin
        prev_clk <= cpu_clk;
        if (cpu_clk === 1'b1 && prev_clk === 1'b0) rises <= rises + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
        if (cpu_clk === 1'b1) hi_len <= hi_len + 1;
        else begin
            if (hi_len > 0 && aresetn) check(hi_len >= 2, 32'h1);
            hi_len <= 0;
        end
    end

    task automatic stop_test();
        $display("Checks run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic axi_write(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s,
                             output logic [1:0] resp);
        int n;
        n = 0;
        resp = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            n++;
            if (n > 100) begin
                failures++;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [15:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        n = 0;
        v = '1;
        resp = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            n++;
            if (n > 100) begin
                failures++;
                break;
            end
        end
    endtask

    task automatic wr(input logic [3:0] v);
        axi_write(ADDR, {28'h0, v}, 4'hf, r);
        check(r, ccvs_pkg::RESP_OKAY);
    endtask

    task automatic rd(input logic [3:0] exp);
        axi_read(ADDR, d, r);
        check(r, ccvs_pkg::RESP_OKAY);
        check(d, {28'h0, exp});
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic wait_src(input logic exp);
        int n;
        for (n = 0; n < 300 && act_fast !== exp; n++) @(posedge aclk);
        check(act_fast, exp);
    endtask

    task automatic measure();
        int r0, t0, dr, dt;
        r0 = rises;
        t0 = ticks;
        repeat (256) @(posedge aclk);
        dr = rises - r0;
        dt = ticks - t0;
        check(dt > 4 && dr >= 2 * dt - 2 && dr <= 2 * dt + 2, 32'h1);
    endtask

    task automatic end_test(input string name);
        $display("Test %s done", name);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        stop_test();
    end

    initial begin
        do_reset();
        check({fast_en, core_lvl, act_fast}, 32'h0);
        rd(4'h0);
        end_test("reset");
        foreach (rows[i]) begin
            wr(rows[i][15:12]);
            rd(rows[i][11:8]);
            check(fast_en, rows[i][4]);
            check(core_lvl, rows[i][0]);
        end
        end_test("table");
        axi_write(ADDR, 32'h0000_000d, 4'he, r);
        check(r, ccvs_pkg::RESP_OKAY);
        rd(4'h0);
        axi_write(16'hff04, 32'h0000_000d, 4'hf, r);
        check(r, ccvs_pkg::RESP_SLVERR);
        axi_read(16'hff04, d, r);
        check(r, ccvs_pkg::RESP_SLVERR);
        check(d, 32'h0000_0000);
        rd(4'h0);
        end_test("bus");
        rc_opt <= 1'b1;
        repeat (4) @(posedge aclk);
        check(core_lvl, 1'b1);
        wr(4'h8);
        rd(4'h8);
        wr(4'h0);
        check(core_lvl, 1'b1);
        rc_opt <= 1'b0;
        repeat (4) @(posedge aclk);
        check(core_lvl, 1'b0);
        wait_src(1'b0);
        end_test("strap");
        measure();
        // Order kept; settling waits are left out, the block does not time them
        wr(4'h1);
        wr(4'h5);
        wr(4'hd);
        wait_src(1'b1);
        measure();
        wr(4'h5);
        wait_src(1'b0);
        wr(4'h1);
        wr(4'h0);
        check({fast_en, core_lvl}, 32'h0);
        end_test("switch");
        wr(4'hd);
        do_reset();
        check({fast_en, core_lvl, act_fast}, 32'h0);
        rd(4'h0);
        end_test("midreset");
        stop_test();
    end
endmodule
